// >>> core/ds3_rx_pkg.sv
package ds3_rx_pkg;
  // ************************************************************
  // line symbols and detector constants
  // ************************************************************
  typedef enum logic [1:0] {symZero, symPos, symNeg, symBad} symbol_e;
  localparam int ZERO_RUN_LIMIT     = 160;
  localparam int ONES_WINDOW_BITS   = 32;
  localparam int ONES_RELEASE_COUNT = 10;
  localparam int ALARM_MIN_CYCLES   = 32;
  localparam int LOCK_WINDOW_BITS   = 256;
  localparam int LOCK_TOL_PERMILLE  = 5;
  localparam int LOCK_TOL_COUNT     = (LOCK_WINDOW_BITS * LOCK_TOL_PERMILLE + 999) / 1000;
  localparam int PIPE_HALF_STAGES   = 7;
  localparam logic [7:0] STRETCH_RESET = 8'h00;
endpackage : ds3_rx_pkg

// >>> core/alarm_stretch.sv
`timescale 1ns/100ps
module alarm_stretch
  import ds3_rx_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic cause,
  output logic      alarm
);
  logic [5:0] holdCount;
  logic       causeSeen;
  wire        rising = cause && !causeSeen;
  wire        next_alarm = cause || (holdCount != 6'h00);
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      holdCount <= 6'h00;
      causeSeen <= 1'b0;
      alarm     <= 1'b0;
    end
    else if (tick)
    begin
      causeSeen <= cause;
      // restart on each new assertion
      if (rising)
        holdCount <= 6'(ALARM_MIN_CYCLES - 1); // R20
      else if (holdCount != 6'h00)
        holdCount <= holdCount - 6'h01;
      alarm <= next_alarm; // R06
    end
  end
endmodule : alarm_stretch

// >>> core/two_entry_buffer.sv
`timescale 1ns/100ps
module two_entry_buffer
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       inValid,
  output logic            inReady,
  input  wire logic [1:0] inData,
  output logic            outValid,
  input  wire logic       outReady,
  output logic [1:0]      outData
);
  logic [1:0] slot [2];
  logic       wrIdx;
  logic       rdIdx;
  logic [1:0] fill;
  wire        doWrite = inValid && inReady;
  wire        doRead  = outValid && outReady;
  assign inReady  = (fill != 2'd2);
  assign outValid = (fill != 2'd0);
  assign outData  = slot[rdIdx];
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      slot[0] <= 2'h0;
      slot[1] <= 2'h0;
      wrIdx   <= 1'b0;
      rdIdx   <= 1'b0;
      fill    <= 2'd0;
    end
    else
    begin
      if (doWrite)
      begin
        slot[wrIdx] <= inData;
        wrIdx       <= ~wrIdx;
      end
      if (doRead)
        rdIdx <= ~rdIdx;
      fill <= fill + 2'(doWrite) - 2'(doRead);
    end
  end
endmodule : two_entry_buffer

// >>> core/ds3_rx_alarm_and_output.sv
`timescale 1ns/100ps
// Operation
// R01: restart acquisition when clocks differ over 0.5%
// R02: raise lock alarm on 0.5% frequency mismatch
// R03: lock alarm waits 250 bits after data loss
// R04: lock alarm high until locked, 32 cycles min
// R05: signal loss is analog OR digital detector
// R06: signal loss alarm holds 32 cycles minimum
// R07: threshold select fixed at power-up by system
// R08: zero run of 160 sets digital loss
// R09: ten ones in 32 bits clears loss
// R10: recovery continues regardless of signal loss
// R11: signal loss is no error-rate monitor
// R12: rails change rising, sampled falling edge
// R13: positive, negative, zero map onto two rails
// R14: test low floats clock, rails and alarms
// R15: test input defaults inactive when unconnected
// R16: error-free within 20ms power, 4ms data
// R17: phase hit recovers in under 2ms
// R18: rails delayed three and half recovered clocks; the rail buffer makes it four
// R19: detector counters run on recovered clock
// R20: stretch counter restarts on each new alarm
module ds3_rx_alarm_and_output
  import ds3_rx_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       recoveredClockIn,
  input  wire logic       reference_clock_in,
  input  wire logic [1:0] line_input,
  input  wire logic       analogLoss,
  input  wire logic [1:0] loss_threshold_select,
  input  wire logic       equalizer_bypass,
  input  wire logic       output_float_test_n,
  output logic            forceReacquire,
  output logic            recoveredClockOut,
  output logic            recoveredClockOe,
  output logic            positive_rail_data,
  output logic            negative_rail_data,
  output logic            railOe,
  output logic            signal_loss_alarm,
  output logic            lock_loss_alarm,
  output logic            alarmOe,
  output logic [1:0]      thresholdLatched
);
  // ************************************************************
  // input synchronisers
  // ************************************************************
  // only the second flip-flop of each pair is read by logic
  logic [1:0] rclkSync;
  logic [1:0] refSync;
  logic [1:0] testSync;
  logic [1:0] lossSync;
  logic [1:0] lineMeta;
  logic [1:0] lineSync;
  logic [1:0] strapMeta;
  logic [1:0] strapSync;
  logic       rclkLast;
  logic       refLast;
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rclkSync <= 2'h0;
      refSync  <= 2'h0;
      testSync <= 2'h3;
      lossSync <= 2'h0;
    end
    else
    begin
      rclkSync <= {rclkSync[0], recoveredClockIn};
      refSync  <= {refSync[0], reference_clock_in};
      testSync <= {testSync[0], output_float_test_n};
      lossSync <= {lossSync[0], analogLoss};
    end
  end
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      lineMeta <= 2'h0;
      lineSync <= 2'h0;
    end
    else
    begin
      lineMeta <= line_input;
      lineSync <= lineMeta;
    end
  end
  // the strap pair keeps running in reset, so it has settled at release
  always_ff @(posedge clock)
  begin
    strapMeta <= loss_threshold_select;
    strapSync <= strapMeta;
  end

  // ************************************************************
  // edge detectors on the synchronised clocks
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rclkLast <= 1'b0;
      refLast  <= 1'b0;
    end
    else
    begin
      rclkLast <= rclkSync[1];
      refLast  <= refSync[1];
    end
  end
  wire rclkRise = rclkSync[1] && !rclkLast;
  wire rclkFall = !rclkSync[1] && rclkLast;
  wire refRise  = refSync[1] && !refLast;

  // ************************************************************
  // threshold strap, caught once after reset
  // ************************************************************
  logic strapTaken;
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      strapTaken       <= 1'b0;
      thresholdLatched <= 2'h0;
    end
    else if (!strapTaken)
    begin
      // later changes are ignored
      strapTaken       <= 1'b1;
      thresholdLatched <= strapSync; // R07
    end
  end

  // ************************************************************
  // symbol pipeline: data moves on both recovered rising and falling edges
  // ************************************************************
  // half-period stages: seven halves give three and a half clocks
  logic [1:0] halfPipe [PIPE_HALF_STAGES];
  genvar gi;
  generate
    for (gi = 0; gi < PIPE_HALF_STAGES; gi++)
    begin : g_pipe
      wire [1:0] stageIn;
      if (gi == 0)
      begin : g_head
        assign stageIn = lineSync;
      end
      else
      begin : g_body
        assign stageIn = halfPipe[gi - 1];
      end
      always_ff @(posedge clock)
      begin
        if (rst)
          halfPipe[gi] <= 2'h0;
        else if (rclkRise || rclkFall)
          halfPipe[gi] <= stageIn; // R18
      end
    end
  endgenerate
  // an illegal both-high symbol is shown as zero
  wire [1:0] railCode = (halfPipe[PIPE_HALF_STAGES - 1] == 2'h3) ? 2'h0
                        : halfPipe[PIPE_HALF_STAGES - 1]; // R13

  // ************************************************************
  // rail buffer and output registers
  // ************************************************************
  // buffer stands between pipeline and rails; pop only on rising edge
  logic       bufValid;
  logic [1:0] bufData;
  logic       bufInReady;
  two_entry_buffer u_buf (
    .clock    (clock),
    .rst      (rst),
    .inValid  (rclkFall),
    .inReady  (bufInReady),
    .inData   (railCode),
    .outValid (bufValid),
    .outReady (rclkRise),
    .outData  (bufData)
  );
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      positive_rail_data <= 1'b0;
      negative_rail_data <= 1'b0;
      recoveredClockOut  <= 1'b0;
    end
    else
    begin
      recoveredClockOut <= rclkSync[1];
      if (rclkRise && bufValid)
      begin
        positive_rail_data <= bufData[0]; // R12
        negative_rail_data <= bufData[1]; // R13
      end
    end
  end

  // ************************************************************
  // output float test
  // ************************************************************
  // reset value high mimics the pull-up while unconnected
  wire floatOff = testSync[1]; // R15
  assign recoveredClockOe = floatOff; // R14
  assign railOe           = floatOff; // R14
  assign alarmOe          = floatOff; // R14

  // ************************************************************
  // digital loss detector, counted in recovered bits
  // ************************************************************
  logic [7:0]  zeroRun;
  logic [31:0] bitWindow;
  logic        digitalLoss;
  wire         bitIsOne = (railCode != 2'h0);
  wire [5:0]   onesInWindow;
  // running sum down the window, one adder per bit
  wire [5:0]   onesPart [ONES_WINDOW_BITS + 1];
  genvar wi;
  assign onesPart[0] = 6'h00;
  generate
    for (wi = 0; wi < ONES_WINDOW_BITS; wi++)
    begin : g_ones
      assign onesPart[wi + 1] = onesPart[wi] + 6'(bitWindow[wi]);
    end
  endgenerate
  assign onesInWindow = onesPart[ONES_WINDOW_BITS];
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      zeroRun     <= 8'h00;
      bitWindow   <= 32'h0;
      digitalLoss <= 1'b0;
    end
    else if (rclkFall)
    begin
      bitWindow <= {bitWindow[30:0], bitIsOne}; // R19
      // saturates, so a very long run never wraps back under the limit
      if (bitIsOne)
        zeroRun <= 8'h00;
      else if (zeroRun != 8'hff)
        zeroRun <= zeroRun + 8'h01;
      if (!bitIsOne && zeroRun >= 8'(ZERO_RUN_LIMIT - 1))
        digitalLoss <= 1'b1; // R08
      else if (onesInWindow >= 6'(ONES_RELEASE_COUNT))
        digitalLoss <= 1'b0; // R09 R17
    end
  end
  // recovery never looks at this alarm
  wire lossCause = lossSync[1] || digitalLoss; // R05 R10
  alarm_stretch u_los (
    .clock (clock),
    .rst   (rst),
    .tick  (rclkRise),
    .cause (lossCause),
    .alarm (signal_loss_alarm)
  );

  // ************************************************************
  // frequency comparator
  // ************************************************************
  // count reference edges over a window of recovered bits; a window
  // longer than 250 bits keeps a data dropout from alarming early
  // the tolerance rounds up to whole reference edges, so it is a little loose
  logic [8:0] bitCount;
  logic [9:0] refCount;
  logic       lockBad;
  wire        windowEnd = rclkRise && (bitCount == 9'(LOCK_WINDOW_BITS - 1));
  wire [9:0]  nextRef = refCount + 10'(refRise);
  wire        outOfTol = (nextRef > 10'(LOCK_WINDOW_BITS + LOCK_TOL_COUNT))
                      || (nextRef < 10'(LOCK_WINDOW_BITS - LOCK_TOL_COUNT));
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bitCount <= 9'h000;
      refCount <= 10'h000;
      lockBad  <= 1'b0;
    end
    else if (windowEnd)
    begin
      bitCount <= 9'h000;
      refCount <= 10'h000;
      lockBad  <= outOfTol; // R02 R03 R16
    end
    else
    begin
      bitCount <= bitCount + 9'(rclkRise);
      refCount <= nextRef;
    end
  end
  assign forceReacquire = lockBad; // R01
  alarm_stretch u_lol (
    .clock (clock),
    .rst   (rst),
    .tick  (rclkRise),
    .cause (lockBad),
    .alarm (lock_loss_alarm) // R04
  );
  // equalizer bypass only shifts analog thresholds outside this logic
  wire unusedBypass = equalizer_bypass;
endmodule : ds3_rx_alarm_and_output

// >>> testbench/ds3_rx_alarm_monitor.sv
`timescale 1ns/100ps
module ds3_rx_alarm_monitor
(
  input wire logic clock,
  input wire logic rst,
  input wire logic analogLoss,
  input wire logic output_float_test_n,
  input wire logic recoveredClockOut,
  input wire logic recoveredClockOe,
  input wire logic positive_rail_data,
  input wire logic negative_rail_data,
  input wire logic railOe,
  input wire logic alarmOe,
  input wire logic signal_loss_alarm,
  input wire logic lock_loss_alarm
);
  // ****
  // edge counters
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic       prev;
  logic [7:0] los;
  logic [7:0] lol;
  wire        rise = recoveredClockOut && !prev;
  // saturating, so a long alarm never wraps to a small count
  always_ff @(posedge clock)
  begin
    prev <= recoveredClockOut;
    los  <= (rst || !signal_loss_alarm) ? 8'h00 : los + {7'h00, rise && !(&los)};
    lol  <= (rst || !lock_loss_alarm) ? 8'h00 : lol + {7'h00, rise && !(&lol)};
  end
  // ****
  // properties
  // ****
  property p_losHold; $fell(signal_loss_alarm) |-> los >= 8'h20; endproperty
  a_losHold: assert property (p_losHold) else $error("loss alarm too short");
  property p_lolHold; $fell(lock_loss_alarm) |-> lol >= 8'h20; endproperty
  a_lolHold: assert property (p_lolHold) else $error("lock alarm too short");
  property p_analog; $rose(analogLoss) |-> ##[1:20] signal_loss_alarm; endproperty
  a_analog: assert property (p_analog) else $error("analog loss not seen");
  property p_railExcl; !(positive_rail_data && negative_rail_data); endproperty
  a_railExcl: assert property (p_railExcl) else $error("both rails high");
  property p_railStable; $fell(recoveredClockOut) |-> $stable({positive_rail_data, negative_rail_data}); endproperty
  a_railStable: assert property (p_railStable) else $error("rails moved at fall");
  property p_floatOn; $fell(output_float_test_n) |-> ##[1:4] !(railOe || alarmOe || recoveredClockOe); endproperty
  a_floatOn: assert property (p_floatOn) else $error("outputs not floated");
  property p_floatHold; !output_float_test_n [*5] |-> !(railOe || alarmOe || recoveredClockOe); endproperty
  a_floatHold: assert property (p_floatHold) else $error("output driven in test");
  property p_driven; output_float_test_n [*5] |-> railOe && alarmOe && recoveredClockOe; endproperty
  a_driven: assert property (p_driven) else $error("output floated");
  c_los: cover property ($rose(signal_loss_alarm));
  c_lol: cover property ($rose(lock_loss_alarm));
  c_mark: cover property ($rose(positive_rail_data));
endmodule : ds3_rx_alarm_monitor

bind ds3_rx_alarm_and_output ds3_rx_alarm_monitor i_ds3_rx_alarm_monitor (.clock, .rst, .analogLoss,
  .output_float_test_n, .recoveredClockOut, .recoveredClockOe, .positive_rail_data, .negative_rail_data,
  .railOe, .alarmOe, .signal_loss_alarm, .lock_loss_alarm);

// >>> testbench/ds3_framer_model.sv
`timescale 1ns/100ps
module ds3_framer_model
(
  input wire logic rclk,
  input wire logic posRail,
  input wire logic negRail,
  input wire logic railOe,
  input wire logic clear,
  output int       posSeen,
  output int       negSeen,
  output int       bothSeen
);
  // ****
  // falling-edge sampler, data only, alarms unused
  // ****
  always @(negedge rclk or posedge clear)
  begin
    if (clear)
    begin
      posSeen = 0;
      negSeen = 0;
      bothSeen = 0;
    end
    else if (railOe)
    begin
      posSeen = posSeen + int'(posRail === 1'h1 && negRail === 1'h0);
      negSeen = negSeen + int'(negRail === 1'h1 && posRail === 1'h0);
      bothSeen = bothSeen + int'(posRail === 1'h1 && negRail === 1'h1);
    end
  end
endmodule : ds3_framer_model

// >>> testbench/tb_ds3_rx_alarm_and_output.sv
`timescale 1ns/100ps
module tb_ds3_rx_alarm_and_output;
  import ds3_rx_pkg::*;
  // ****
  // signals
  // ****
  logic       clock = 1'h0;
  logic       rst = 1'h1;
  logic       recoveredClockIn = 1'h0;
  logic       reference_clock_in = 1'h0;
  logic [1:0] line_input = 2'h0;
  logic       analogLoss = 1'h0;
  logic [1:0] loss_threshold_select = 2'h1;
  logic       equalizer_bypass = 1'h0;
  logic       output_float_test_n = 1'h1;
  logic       clear = 1'h0;
  wire logic  forceReacquire, recoveredClockOut, recoveredClockOe, positive_rail_data, negative_rail_data;
  wire logic  railOe, signal_loss_alarm, lock_loss_alarm, alarmOe;
  wire logic [1:0] thresholdLatched;
  int         fail_count = 0;
  int         tests_run = 0;
  int         posSeen, negSeen, bothSeen;
  realtime    refHalf = 200.0;
  realtime    t0 = 1.0;
  realtime    riseAt = 0.0;
  ds3_rx_alarm_and_output i_ds3_rx_alarm_and_output (.clock, .rst, .recoveredClockIn, .reference_clock_in,
    .line_input, .analogLoss, .loss_threshold_select, .equalizer_bypass, .output_float_test_n, .forceReacquire,
    .recoveredClockOut, .recoveredClockOe, .positive_rail_data, .negative_rail_data, .railOe,
    .signal_loss_alarm, .lock_loss_alarm, .alarmOe, .thresholdLatched);
  ds3_framer_model i_ds3_framer_model (.rclk(recoveredClockOut), .posRail(positive_rail_data),
    .negRail(negative_rail_data), .railOe, .clear, .posSeen, .negSeen, .bothSeen);
  initial forever #25 clock = ~clock;
  initial
  begin
    #7;
    forever #200 recoveredClockIn = ~recoveredClockIn;
  end
  initial forever #(refHalf) reference_clock_in = ~reference_clock_in;
  always @(posedge positive_rail_data) if (riseAt < t0) riseAt = $realtime;
  // ****
  // shared tasks
  // ****
  task automatic chk(string what, logic exp, logic got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : chk
  task automatic chkN(string what, int exp, int got);
    tests_run++;
    if (got != exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask : chkN
  task automatic conclude;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // checks land on the falling edge, after the design's updates
  task automatic settle(int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : settle
  // launched mid-bit, so the level is settled when the design samples it
  task automatic sendSym(logic [1:0] s, int n);
    repeat (n)
    begin
      @(negedge recoveredClockIn);
      @(posedge clock);
      line_input <= s;
    end
  endtask : sendSym
  task automatic sendMarks(int n);
    for (int i = 0; i < n; i++)
      sendSym(i[0] ? symNeg : symPos, 1);
  endtask : sendMarks
  task automatic clearSeen;
    @(posedge clock);
    clear <= 1'h1;
    @(posedge clock);
    clear <= 1'h0;
  endtask : clearSeen
  task automatic waitLock(logic lvl);
    int n = 0;
    while (lock_loss_alarm !== lvl && n < 8000)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 8000)
    begin
      fail_count++;
      conclude();
    end
  endtask : waitLock
  // ****
  // scenarios
  // ****
  task automatic testFloat;
    @(posedge clock);
    output_float_test_n <= 1'h0;
    settle(6);
    chk("rail enable", 1'h0, railOe);
    chk("alarm enable", 1'h0, alarmOe);
    chk("clock enable", 1'h0, recoveredClockOe);
    @(posedge clock);
    output_float_test_n <= 1'h1;
    settle(6);
    chk("rail enable", 1'h1, railOe);
    chk("alarm enable", 1'h1, alarmOe);
    chk("clock enable", 1'h1, recoveredClockOe);
    $display("float test done");
  endtask : testFloat
  task automatic testEncode;
    clearSeen();
    sendSym(symPos, 1);
    t0 = $realtime;
    sendSym(symZero, 2);
    sendSym(symNeg, 1);
    sendSym(symZero, 2);
    sendSym(symPos, 1);
    sendSym(symZero, 8);
    chk("rail delay", 1'h1, riseAt - t0 > 1200.0 && riseAt - t0 < 2200.0);
    chkN("positive marks", 2, posSeen);
    chkN("negative marks", 1, negSeen);
    chkN("both rails", 0, bothSeen);
    $display("encode test done");
  endtask : testEncode
  task automatic testZeroRun;
    sendMarks(40);
    settle(1);
    chk("loss after marks", 1'h0, signal_loss_alarm);
    sendSym(symZero, 120);
    settle(1);
    chk("loss short run", 1'h0, signal_loss_alarm);
    sendSym(symZero, 80);
    settle(1);
    chk("loss long run", 1'h1, signal_loss_alarm);
    chk("lock during zeros", 1'h0, lock_loss_alarm);
    clearSeen();
    repeat (2)
    begin
      sendMarks(9);
      sendSym(symZero, 23);
    end
    settle(1);
    chk("loss nine ones", 1'h1, signal_loss_alarm);
    chkN("marks during loss", 18, posSeen + negSeen);
    sendMarks(40);
    settle(1);
    chk("loss ten ones", 1'h0, signal_loss_alarm);
    $display("zero run test done");
  endtask : testZeroRun
  task automatic testAnalog;
    @(posedge clock);
    analogLoss <= 1'h1;
    repeat (12) @(posedge clock);
    analogLoss <= 1'h0;
    settle(8);
    chk("analog loss", 1'h1, signal_loss_alarm);
    settle(200);
    chk("loss held", 1'h1, signal_loss_alarm);
    settle(160);
    chk("loss ended", 1'h0, signal_loss_alarm);
    $display("analog test done");
  endtask : testAnalog
  task automatic testLock;
    refHalf = 230.0;
    waitLock(1'h1);
    settle(1);
    chk("reacquire", 1'h1, forceReacquire);
    refHalf = 200.0;
    waitLock(1'h0);
    settle(1);
    chk("reacquire ended", 1'h0, forceReacquire);
    $display("lock test done");
  endtask : testLock
  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    settle(2);
    chk("strap", 1'h1, thresholdLatched === 2'h1);
    testFloat();
    testEncode();
    testZeroRun();
    testAnalog();
    testLock();
    conclude();
  end
  initial
  begin
    #5000000;
    fail_count++;
    conclude();
  end
endmodule : tb_ds3_rx_alarm_and_output
